/* File: hdl/usbb_regs.svh */
/*
 * Register offsets, field positions, reset values and counts for the
 * sleep, idle/break and baud generator block of one UART channel.
 * Assumes the includer compiles it once per unit; guarded for reuse.
 */
// Operation
// - Sleep is possible only with both the enhanced-functions and sleep-enable bits set.
// - With sleep enabled, sleep needs rx idle, tx FIFO and shifter empty, no other interrupt.
// - Sleep is never entered while the receive FIFO holds a character.
// - While asleep the UART clock and the baud clock are stopped so their state holds.
// - Any rx line change, modem pin change or transmit FIFO write wakes the block.
// - The rx line is idle after staying high for four character times.
// - The rx line is sampled in the middle of each bit.
// - While the break-control bit is set the transmit output is forced low.
// - The baud generator divides its prescaled clock by any divisor from 1 to 65535.
// - The prescaler-select bit picks divide by one when clear and divide by four when set.
// - The generator output runs at 16x baud, input clock over prescaler then divisor.
// - The divisor is the low-byte latch below the high-byte latch, both written by the host.
// - A zero divisor produces no baud clock, leaving the serial functions inactive.
// - One baud generator output times both transmitter and receiver.
// - Reset leaves both divisor latches unchanged.
`ifndef USBB_REGS_SVH
`define USBB_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define USBB_OFF_DIV_LO    4'h0
`define USBB_OFF_DIV_HI    4'h1
`define USBB_OFF_IER       4'h2
`define USBB_OFF_LCR       4'h3
`define USBB_OFF_MCR       4'h4
`define USBB_OFF_EFR       4'h5
`define USBB_OFF_STATUS    4'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USBB_IER_SLEEP_BIT 4
`define USBB_EFR_ENH_BIT   4
`define USBB_LCR_BRK_BIT   6
`define USBB_LCR_PAR_BIT   3
`define USBB_LCR_STOP_BIT  2
`define USBB_MCR_PRE_BIT   7
`define USBB_ST_ASLEEP_BIT 0
`define USBB_ST_IDLE_BIT   1
`define USBB_ST_NOCLK_BIT  2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define USBB_RST_CTRL      8'h00
`define USBB_RST_DATA      8'h00
`define USBB_IDLE_CHARS    6'h04
`define USBB_MID_PHASE     4'h7
`define USBB_PRE_LAST      2'h3
`define USBB_CHAR_BASE     4'h7

`endif

/* File: hdl/usbb_pkg.sv */
/*
 * Types shared by the sleep/break/baud block and its baud generator.
 * Assumes the constants header supplies every number.
 */
package usbb_pkg;

    // Power state of the channel
    typedef enum logic [0:0] {
        USBB_AWAKE  = 1'b0,
        USBB_ASLEEP = 1'b1
    } usbb_pwr_e;

    // Control bits decoded from the software registers
    typedef struct packed {
        logic       sleep_allow;
        logic       brk;
        logic       pre_div4;
        logic [1:0] word_len;
        logic       two_stop;
        logic       par_en;
    } usbb_cfg_s;

    // Divisor load request for the baud generator
    typedef struct packed {
        logic        reload;
        logic [15:0] divisor;
    } usbb_div_s;

endpackage

/* File: hdl/usbb_baud_gen.sv */
/*
 * Prescaler and 16-bit divider that make the 16x baud tick.
 * Assumes the parent holds the divisor latches and the run enable.
 */
`include "usbb_regs.svh"

module usbb_baud_gen (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    input  wire logic              run_in,
    input  wire logic              pre_div4_in,
    input  wire usbb_pkg::usbb_div_s div_in,
    output logic                   tick_out
);

    logic [1:0]  pre_cnt_r;
    logic [1:0]  pre_cnt_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;
    logic        pre_ok;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    // A stopped generator holds its count so the phase resumes on wake
    always_comb begin
        pre_cnt_nxt = pre_cnt_r;
        cnt_nxt     = cnt_r;
        tick_nxt    = 1'b0;
        pre_ok      = !pre_div4_in || (pre_cnt_r == `USBB_PRE_LAST);
        if (div_in.reload) begin
            pre_cnt_nxt = 2'h0;
            cnt_nxt     = div_in.divisor;
        end else if (run_in) begin
            pre_cnt_nxt = pre_cnt_r + 2'h1;
            if (pre_ok) begin
                if (cnt_r <= 16'h0001) begin
                    cnt_nxt  = div_in.divisor;
                    tick_nxt = (div_in.divisor != 16'h0000);
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_cnt_r <= 2'h0;
            cnt_r     <= 16'h0000;
            tick_r    <= 1'b0;
        end else if (ce_in) begin
            pre_cnt_r <= pre_cnt_nxt;
            cnt_r     <= cnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    assign tick_out = tick_r;

endmodule

/* File: hdl/usbb_sleep_core.sv */
/*
 * Sleep control, rx idle detection, break forcing and register port
 * for one UART channel; instantiates the baud generator.
 * Assumes rx and modem pins are asynchronous; all other inputs come
 * from logic on clk_in. Register reads answer one cycle later.
 */
// Implementation choices: the strobed register port and the address map.
`include "usbb_regs.svh"

module usbb_sleep_core (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       rx_pin_in,
    input  wire logic [3:0] modem_pins_in,
    input  wire logic       tx_data_in,
    input  wire logic       tx_write_in,
    input  wire logic       tx_fifo_empty_in,
    input  wire logic       tx_shift_empty_in,
    input  wire logic       rx_fifo_empty_in,
    input  wire logic       other_irq_in,
    output logic            tx_out,
    output logic            baud_tick_out,
    output logic            uart_clk_en_out,
    output logic            asleep_out,
    output logic            rx_idle_out
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Same compare serves every write select; reads decode the offset with a case
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]          div_lo_r;
    logic [7:0]          div_lo_nxt;
    logic [7:0]          div_hi_r;
    logic [7:0]          div_hi_nxt;
    logic [7:0]          ier_r;
    logic [7:0]          ier_nxt;
    logic [7:0]          lcr_r;
    logic [7:0]          lcr_nxt;
    logic [7:0]          mcr_r;
    logic [7:0]          mcr_nxt;
    logic [7:0]          efr_r;
    logic [7:0]          efr_nxt;
    logic [7:0]          rdata_r;
    logic [7:0]          rdata_nxt;
    logic [4:0]          pin_s1_r;
    logic [4:0]          pin_s2_r;
    logic [4:0]          pin_q_r;
    logic [3:0]          phase_r;
    logic [3:0]          phase_nxt;
    logic [5:0]          idle_cnt_r;
    logic [5:0]          idle_cnt_nxt;
    logic                idle_r;
    logic                idle_nxt;
    usbb_pkg::usbb_pwr_e pwr_r;
    usbb_pkg::usbb_pwr_e pwr_nxt;
    logic                tx_r;
    logic                tx_nxt;
    logic                clk_en_r;
    logic                asleep_r;
    logic                tick;
    logic                rx_edge;
    logic                modem_edge;
    logic                wake;
    logic                enter_ok;
    logic                div_wr;
    logic [3:0]          char_bits;
    logic [5:0]          idle_limit;
    usbb_pkg::usbb_cfg_s cfg;
    usbb_pkg::usbb_div_s div;

    // ----------------------------------------------------------------
    // Control decode
    // ----------------------------------------------------------------
    // Break and prescaler act straight from the register bits
    always_comb begin
        cfg.sleep_allow = efr_r[`USBB_EFR_ENH_BIT] && ier_r[`USBB_IER_SLEEP_BIT];
        cfg.brk         = lcr_r[`USBB_LCR_BRK_BIT];
        cfg.pre_div4    = mcr_r[`USBB_MCR_PRE_BIT];
        cfg.word_len    = lcr_r[1:0];
        cfg.two_stop    = lcr_r[`USBB_LCR_STOP_BIT];
        cfg.par_en      = lcr_r[`USBB_LCR_PAR_BIT];
    end

    // Divisor built from the two latches, reloaded on either write
    always_comb begin
        div_wr      = wr_in && (hit(addr_in, `USBB_OFF_DIV_LO) ||
                                hit(addr_in, `USBB_OFF_DIV_HI));
        div.reload  = div_wr;
        div.divisor = {div_hi_nxt, div_lo_nxt};
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Host is trusted not to touch the divisor during sleep
    always_comb begin
        div_lo_nxt = div_lo_r;
        div_hi_nxt = div_hi_r;
        ier_nxt    = ier_r;
        lcr_nxt    = lcr_r;
        mcr_nxt    = mcr_r;
        efr_nxt    = efr_r;
        if (wr_in) begin
            if (hit(addr_in, `USBB_OFF_DIV_LO)) begin
                div_lo_nxt = wdata_in;
            end
            if (hit(addr_in, `USBB_OFF_DIV_HI)) begin
                div_hi_nxt = wdata_in;
            end
            if (hit(addr_in, `USBB_OFF_IER)) begin
                ier_nxt = wdata_in;
            end
            if (hit(addr_in, `USBB_OFF_LCR)) begin
                lcr_nxt = wdata_in;
            end
            if (hit(addr_in, `USBB_OFF_MCR)) begin
                mcr_nxt = wdata_in;
            end
            if (hit(addr_in, `USBB_OFF_EFR)) begin
                efr_nxt = wdata_in;
            end
        end
    end

    // Register reads; unmapped offsets and idle cycles return zero
    always_comb begin
        rdata_nxt = `USBB_RST_DATA;
        if (rd_in) begin
            case (addr_in)
                `USBB_OFF_DIV_LO: begin
                    rdata_nxt = div_lo_r;
                end
                `USBB_OFF_DIV_HI: begin
                    rdata_nxt = div_hi_r;
                end
                `USBB_OFF_IER: begin
                    rdata_nxt = ier_r;
                end
                `USBB_OFF_LCR: begin
                    rdata_nxt = lcr_r;
                end
                `USBB_OFF_MCR: begin
                    rdata_nxt = mcr_r;
                end
                `USBB_OFF_EFR: begin
                    rdata_nxt = efr_r;
                end
                `USBB_OFF_STATUS: begin
                    rdata_nxt[`USBB_ST_ASLEEP_BIT] = asleep_r;
                    rdata_nxt[`USBB_ST_IDLE_BIT]   = idle_r;
                    rdata_nxt[`USBB_ST_NOCLK_BIT]  = ({div_hi_r, div_lo_r} == 16'h0000);
                end
                default: begin
                    rdata_nxt = `USBB_RST_DATA;
                end
            endcase
        end
    end

    // Divisor latches have no reset so a programmed divisor survives it
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            div_lo_r <= div_lo_nxt;
            div_hi_r <= div_hi_nxt;
        end
    end

    // Control registers and read data
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ier_r   <= `USBB_RST_CTRL;
            lcr_r   <= `USBB_RST_CTRL;
            mcr_r   <= `USBB_RST_CTRL;
            efr_r   <= `USBB_RST_CTRL;
            rdata_r <= `USBB_RST_DATA;
        end else if (ce_in) begin
            ier_r   <= ier_nxt;
            lcr_r   <= lcr_nxt;
            mcr_r   <= mcr_nxt;
            efr_r   <= efr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Bit 4 is rx, bits 3:0 the modem inputs; edges compare stage two with pin_q_r
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_s1_r <= 5'h1F;
            pin_s2_r <= 5'h1F;
            pin_q_r  <= 5'h1F;
        end else if (ce_in) begin
            pin_s1_r <= {rx_pin_in, modem_pins_in};
            pin_s2_r <= pin_s1_r;
            pin_q_r  <= pin_s2_r;
        end
    end

    assign rx_edge    = pin_s2_r[4] ^ pin_q_r[4];
    assign modem_edge = |(pin_s2_r[3:0] ^ pin_q_r[3:0]);

    // ----------------------------------------------------------------
    // Rx idle detection
    // ----------------------------------------------------------------
    // Character time in bits: start, data, parity, stop bits
    always_comb begin
        char_bits  = `USBB_CHAR_BASE + {2'h0, cfg.word_len}
                     + {3'h0, cfg.par_en} + {3'h0, cfg.two_stop};
        idle_limit = {2'h0, char_bits} * `USBB_IDLE_CHARS;
    end

    // Phase restarts on every line edge so sampling tracks bit centres.
    // Runs only on baud ticks, so it freezes with the baud clock in sleep.
    always_comb begin
        phase_nxt    = phase_r;
        idle_cnt_nxt = idle_cnt_r;
        idle_nxt     = idle_r;
        if (rx_edge) begin
            phase_nxt    = 4'h0;
            idle_cnt_nxt = 6'h00;
            idle_nxt     = 1'b0;
        end else if (tick) begin
            phase_nxt = phase_r + 4'h1;
            if (phase_r == `USBB_MID_PHASE) begin
                if (!pin_s2_r[4]) begin
                    idle_cnt_nxt = 6'h00;
                    idle_nxt     = 1'b0;
                end else if (idle_cnt_r < idle_limit) begin
                    idle_cnt_nxt = idle_cnt_r + 6'h01;
                    idle_nxt     = ((idle_cnt_r + 6'h01) >= idle_limit);
                end else begin
                    idle_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_r    <= 4'h0;
            idle_cnt_r <= 6'h00;
            idle_r     <= 1'b0;
        end else if (ce_in) begin
            phase_r    <= phase_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            idle_r     <= idle_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Sleep control
    // ----------------------------------------------------------------
    // A wake event in the same cycle as the entry conditions keeps us up
    always_comb begin
        wake     = rx_edge || modem_edge || tx_write_in;
        enter_ok = cfg.sleep_allow && idle_r
                   && tx_fifo_empty_in && tx_shift_empty_in
                   && !other_irq_in
                   && rx_fifo_empty_in
                   && !wake;
        case (pwr_r)
            usbb_pkg::USBB_AWAKE: begin
                pwr_nxt = enter_ok ? usbb_pkg::USBB_ASLEEP : usbb_pkg::USBB_AWAKE;
            end
            usbb_pkg::USBB_ASLEEP: begin
                // Clearing sleep-enable also wakes, as the host is told to
                pwr_nxt = (wake || !cfg.sleep_allow) ? usbb_pkg::USBB_AWAKE
                                                     : usbb_pkg::USBB_ASLEEP;
            end
            default: begin
                pwr_nxt = usbb_pkg::USBB_AWAKE;
            end
        endcase
    end

    // Break forces the line low; otherwise pass the transmitter's bit
    always_comb begin
        tx_nxt = cfg.brk ? 1'b0 : tx_data_in;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwr_r    <= usbb_pkg::USBB_AWAKE;
            clk_en_r <= 1'b1;
            asleep_r <= 1'b0;
            tx_r     <= 1'b1;
        end else if (ce_in) begin
            pwr_r    <= pwr_nxt;
            clk_en_r <= (pwr_nxt == usbb_pkg::USBB_AWAKE);
            asleep_r <= (pwr_nxt == usbb_pkg::USBB_ASLEEP);
            tx_r     <= tx_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Baud generator
    // ----------------------------------------------------------------
    // One tick stream times both directions; stopped while asleep
    usbb_baud_gen u_baud (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .run_in      (clk_en_r),
        .pre_div4_in (cfg.pre_div4),
        .div_in      (div),
        .tick_out    (tick)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata_out       = rdata_r;
    assign tx_out          = tx_r;
    assign baud_tick_out   = tick;
    assign uart_clk_en_out = clk_en_r;
    assign asleep_out      = asleep_r;
    assign rx_idle_out     = idle_r;

endmodule

/* File: verification/usbb_checker.sv */
/*
 * Port checker for usbb_sleep_core: sleep, break, idle and baud timing.
 * Assumes one clock, ce_in held high, bound by name at the foot.
 */
module usbb_checker (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       rx_pin_in,
    input wire logic [3:0] modem_pins_in,
    input wire logic       tx_data_in,
    input wire logic       tx_write_in,
    input wire logic       tx_fifo_empty_in,
    input wire logic       tx_shift_empty_in,
    input wire logic       rx_fifo_empty_in,
    input wire logic       other_irq_in,
    input wire logic       tx_out,
    input wire logic       baud_tick_out,
    input wire logic       uart_clk_en_out,
    input wire logic       asleep_out,
    input wire logic       rx_idle_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Shadow copies of the control bits
    // ----------------------------------------
    logic [7:0]  lo_r, hi_r;
    logic        brk_r, pre_r, ier_r, efr_r, ok_r;
    logic [19:0] gap_r;
    wire [15:0]  div_w = {hi_r, lo_r};
    wire [19:0]  exp_w = pre_r ? {2'h0, div_w, 2'h0} : {4'h0, div_w};
    wire         en_w = ier_r && efr_r;
    wire         zero_w = (div_w == 16'h0000);
    wire         cond_w = tx_fifo_empty_in && tx_shift_empty_in && rx_fifo_empty_in
                          && !other_irq_in && rx_idle_out;
    wire         rate_wr = wr_in && (addr_in == 4'h0 || addr_in == 4'h1 || addr_in == 4'h4);

    // Divisor shadows skip reset, like the latches; gap restarts on every tick, any rate change clears ok_r
    always_ff @(posedge clk_in) begin
        if (wr_in && addr_in == 4'h0) lo_r <= wdata_in;
        if (wr_in && addr_in == 4'h1) hi_r <= wdata_in;
        if (rst_in) begin
            {brk_r, pre_r, ier_r, efr_r, ok_r} <= 5'h00;
            gap_r <= 20'h00000;
        end else begin
            if (wr_in && addr_in == 4'h3) brk_r <= wdata_in[6];
            if (wr_in && addr_in == 4'h4) pre_r <= wdata_in[7];
            if (wr_in && addr_in == 4'h2) ier_r <= wdata_in[4];
            if (wr_in && addr_in == 4'h5) efr_r <= wdata_in[4];
            gap_r <= baud_tick_out ? 20'h00001 : gap_r + 20'h00001;
            ok_r <= (rate_wr || asleep_out) ? 1'b0 : (baud_tick_out | ok_r);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_break_low: assert property (brk_r |=> !tx_out)
        else $error("tx high while break set");
    a_tx_follow: assert property (!brk_r |=> tx_out == $past(tx_data_in))
        else $error("tx does not follow data");
    a_clk_gated: assert property (asleep_out != uart_clk_en_out)
        else $error("clock enable disagrees with sleep");
    a_tick_frozen: assert property (asleep_out && $past(asleep_out) |-> !baud_tick_out)
        else $error("tick while asleep");
    a_sleep_enable: assert property ($rose(asleep_out) |-> $past(en_w))
        else $error("sleep without both enables");
    a_sleep_cond: assert property ($rose(asleep_out) |-> $past(cond_w))
        else $error("sleep with a blocking condition");
    a_wake_write: assert property (asleep_out && tx_write_in |=> !asleep_out)
        else $error("no wake on tx write");
    a_wake_pins: assert property (asleep_out && ($changed(rx_pin_in) ||
        $changed(modem_pins_in)) |-> ##[1:5] !asleep_out)
        else $error("no wake on pin change");
    a_idle_drop: assert property (rx_idle_out && $fell(rx_pin_in) |->
        ##[1:5] !rx_idle_out)
        else $error("idle kept after rx edge");
    a_read_quiet: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside read slot");
    a_no_clock: assert property (zero_w && $past(zero_w) |-> !baud_tick_out)
        else $error("tick with zero divisor");
    a_tick_gap: assert property (baud_tick_out && ok_r |-> gap_r == exp_w)
        else $error("tick spacing wrong");
endmodule

bind usbb_sleep_core usbb_checker chk (.*);

/* File: verification/usbb_far_end.sv */
/*
 * Remote serial device: drives the receive line, watches transmit.
 * Assumes the bench asks for a space level through hold_low_in.
 */
module usbb_far_end (
    input  wire logic  clk_in,
    input  wire logic  hold_low_in,
    input  wire logic  tx_in,
    output logic       rx_out,
    output logic [15:0] low_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_out = 1'b1;
    initial low_cnt_out = 16'h0000;
    // Line rests at mark; run length of low tx shows a break
    always @(posedge clk_in) begin
        rx_out <= !hold_low_in;
        low_cnt_out <= tx_in ? 16'h0000 : low_cnt_out + 16'h0001;
    end
endmodule

/* File: verification/tb_top.sv */
/*
 * Self-checking bench for usbb_sleep_core with a remote serial model.
 * Assumes ce_in may stay high; all inputs move at rising edges.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, rst_in = 1, ce_in = 1, wr_in = 0, rd_in = 0, line_low = 0;
    logic tx_data_in = 1, tx_write_in = 0, other_irq_in = 0, rx_pin_in;
    logic tx_fifo_empty_in = 1, tx_shift_empty_in = 1, rx_fifo_empty_in = 1;
    logic [3:0] addr_in = 0, modem_pins_in = 4'hF;
    logic [7:0] wdata_in = 0, rdata_out;
    logic tx_out, baud_tick_out, uart_clk_en_out, asleep_out, rx_idle_out;
    logic [15:0] low_cnt;
    int bad_count = 0, checked = 0;

    usbb_sleep_core dut (.*);
    usbb_far_end far (.clk_in(clk_in), .hold_low_in(line_low), .tx_in(tx_out),
        .rx_out(rx_pin_in), .low_cnt_out(low_cnt));

    // Clock at 100 MHz
    always #5 clk_in = ~clk_in;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 check(rdata_out & m, exp);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task wait_tick(output int n);
        n = 0;
        do begin @(posedge clk_in); #1 n++; end while (baud_tick_out !== 1'b1 && n < 5000);
    endtask
    // First tick counted from the write edge, so a missed reload shows
    task tick_chk(input int first, input int gap);
        int n;
        wait_tick(n);
        if (first > 0) check(n, first);
        wait_tick(n);
        check(n, gap);
    endtask
    task no_ticks(input int cycles);
        int hits;
        hits = 0;
        repeat (cycles) begin @(posedge clk_in); #1 if (baud_tick_out !== 1'b0) hits++; end
        check(hits, 0);
    endtask
    task wake_chk;
        int n;
        n = 0;
        do begin @(posedge clk_in); #1 n++; end while (asleep_out === 1'b1 && n < 6);
        check(asleep_out, 0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        for (int a = 2; a < 6; a++) rd(a[3:0], 8'h00);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
    endtask
    task t_baud;
        wr(4'h0, 8'h03);
        wr(4'h1, 8'h00);
        tick_chk(3, 3);
        rd(4'h0, 8'h03);
        wr(4'h4, 8'h80);
        tick_chk(0, 12);
        wr(4'h4, 8'h00);
        wr(4'h1, 8'h01);
        wr(4'h0, 8'h00);
        tick_chk(256, 256);
        wr(4'h0, 8'h01);
        wr(4'h1, 8'h00);
        tick_chk(1, 1);
    endtask
    task t_zero;
        wr(4'h0, 8'h00);
        rd(4'h6, 8'h04, 8'h04);
        no_ticks(100);
    endtask
    task t_reset_keep;
        wr(4'h0, 8'h05);
        @(posedge clk_in) rst_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(4'h0, 8'h05);
        rd(4'h1, 8'h00);
        tick_chk(0, 5);
    endtask
    task t_break;
        wr(4'h3, 8'h40);
        cyc(19);
        check(low_cnt, 18);
        wr(4'h3, 8'h00);
        cyc(2);
        check(tx_out, 1);
        @(posedge clk_in) tx_data_in <= 1'b0;
        @(posedge clk_in) tx_data_in <= 1'b1;
        #1 check(tx_out, 0);
    endtask
    // Four characters of mid-bit samples at 16 ticks a bit, bits per character given
    task t_idle(input logic [7:0] line_control_reg, input int bits);
        int n;
        wr(4'h3, line_control_reg);
        wr(4'h0, 8'h01);
        @(posedge clk_in) line_low <= 1'b1;
        cyc(40);
        check(rx_idle_out, 0);
        @(posedge clk_in) line_low <= 1'b0;
        n = 0;
        do begin @(posedge clk_in); #1 n++; end while (rx_idle_out !== 1'b1 && n < 900);
        check(n >= 4 * bits * 16 - 16 && n <= 4 * bits * 16 + 16, 1);
    endtask
    task t_sleep;
        wr(4'h5, 8'h10);
        cyc(10);
        check(asleep_out, 0);
        @(posedge clk_in) rx_fifo_empty_in <= 1'b0;
        wr(4'h2, 8'h10);
        cyc(10);
        check(asleep_out, 0);
        @(posedge clk_in) rx_fifo_empty_in <= 1'b1;
        other_irq_in <= 1'b1;
        cyc(10);
        check(asleep_out, 0);
        @(posedge clk_in) other_irq_in <= 1'b0;
        tx_shift_empty_in <= 1'b0;
        cyc(10);
        check(asleep_out, 0);
        @(posedge clk_in) tx_shift_empty_in <= 1'b1;
        cyc(3);
        check(asleep_out, 1);
        check(uart_clk_en_out, 0);
        no_ticks(30);
        @(posedge clk_in) tx_write_in <= 1'b1;
        @(posedge clk_in) tx_write_in <= 1'b0;
        #1 check(asleep_out, 0);
        cyc(3);
        @(posedge clk_in) modem_pins_in <= 4'hE;
        wake_chk;
        cyc(4);
        @(posedge clk_in) line_low <= 1'b1;
        wake_chk;
        @(posedge clk_in) line_low <= 1'b0;
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h02);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs;
        t_baud;
        t_zero;
        t_reset_keep;
        t_break;
        t_idle(8'h00, 7);
        t_idle(8'h0F, 12);
        t_sleep;
        stop_test;
    end
    // Watchdog: the run needs well under 10000 cycles
    initial begin
        #200000;
        bad_count++;
        stop_test;
    end
endmodule
